//--- include/fault_status_consts.svh
/*
  Constants for the latched fault status register: offset, field positions,
  reset value and channel count.
  Assumes it is included by bare name from design files and the package.
*/
`ifndef FAULT_STATUS_CONSTS_SVH
`define FAULT_STATUS_CONSTS_SVH
`define FAULT_STATUS_ADDR 8'he2
`define FAULT_STATUS_RESET 8'h00
`define STATUS_WIDTH 8
`define INIT_FAIL_BIT 7
`define OVERCURRENT_BASE_BIT 4
`define THERMAL_SHUTDOWN_BIT 3
`define POWER_GOOD_BASE_BIT 0
`define CHANNEL_COUNT 3
`define ENABLES_ALL_LOW 3'h0
`endif

//--- include/fault_status_pkg.sv
/*
  Types shared by the fault status register design.
  Assumes the constants header is on the include path.
*/
`include "fault_status_consts.svh"
package fault_status_pkg;
  typedef logic [7:0] status_byte_t;
  typedef logic [`CHANNEL_COUNT-1:0] channel_vec_t;
endpackage : fault_status_pkg

//--- verilog/sticky_flag.sv
/*
  One sticky flag bit with set-over-clear priority.
  Assumes set, clear and the bulk clear are synchronous to clk.
*/
`timescale 1ns/100ps
`default_nettype none
module sticky_flag
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic set_event,
  input wire logic clear_one,
  input wire logic clear_all,
  output logic flag
);
  logic flag_reg;
  logic flag_next;
  // ==========================================================================
  // Next state
  always_comb
  begin
    flag_next = flag_reg;
    if (clear_one || clear_all)
    begin
      flag_next = 1'b0;
    end
    if (set_event)
    begin
      flag_next = 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      flag_reg <= 1'b0;
    end
    else
    begin
      flag_reg <= flag_next;
    end
  end
  assign flag = flag_reg;
endmodule : sticky_flag
`default_nettype wire

//--- verilog/latched_fault_status.sv
/*
  Latched fault status register: eight sticky fault flags, host read and
  write-one-to-clear at one address, bulk clear when all channels disabled.
  Assumes fault strobes, enables and host access are synchronous to clk and
  that a higher-level serial interface decodes transactions into strobes.
*/
`timescale 1ns/100ps
`default_nettype none
`include "fault_status_consts.svh"
module latched_fault_status
  import fault_status_pkg::*;
#(
  parameter int CHANNELS = `CHANNEL_COUNT
)
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic init_fail_event,
  input wire channel_vec_t overcurrent_event,
  input wire logic thermal_shutdown_event,
  input wire channel_vec_t power_good_fail_event,
  input wire channel_vec_t channel_enable_inputs,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output status_byte_t fault_latch_status
);
  // ==========================================================================
  // Event mapping
  status_byte_t set_vec;
  status_byte_t clear_vec;
  status_byte_t flags;
  logic clear_all;
  logic hit;
  always_comb
  begin
    set_vec = `FAULT_STATUS_RESET;
    set_vec[`INIT_FAIL_BIT] = init_fail_event;
    set_vec[`OVERCURRENT_BASE_BIT +: `CHANNEL_COUNT] = overcurrent_event;
    set_vec[`THERMAL_SHUTDOWN_BIT] = thermal_shutdown_event;
    set_vec[`POWER_GOOD_BASE_BIT +: `CHANNEL_COUNT] = power_good_fail_event;
  end
  assign hit = (reg_addr == `FAULT_STATUS_ADDR);
  // Zero bits of a write leave their flags alone.
  assign clear_vec = (reg_write && hit) ? reg_wdata : `FAULT_STATUS_RESET;
  assign clear_all = (channel_enable_inputs == `ENABLES_ALL_LOW);
  // ==========================================================================
  // Flag bits
  genvar i;
  generate
    for (i = 0; i < `STATUS_WIDTH; i++)
    begin : g_flag
      sticky_flag u_flag
      (
        .clk(clk),
        .rstn(rstn),
        .set_event(set_vec[i]),
        .clear_one(clear_vec[i]),
        .clear_all(clear_all),
        .flag(flags[i])
      );
      // Each bit is checked alone, since one sample bit would hide a miswired neighbour.
      AST_BIT_SET_WINS: assert property (@(posedge clk) disable iff (!rstn)
        set_vec[i]
        |=> flags[i])
        else $error("event lost against a clear");
      AST_BIT_W1C: assert property (@(posedge clk) disable iff (!rstn)
        (clear_vec[i] && !set_vec[i])
        |=> !flags[i])
        else $error("write one left a flag set");
      AST_BIT_BULK: assert property (@(posedge clk) disable iff (!rstn)
        (clear_all && !set_vec[i])
        |=> !flags[i])
        else $error("flag survived all enables low");
      AST_BIT_HOLD: assert property (@(posedge clk) disable iff (!rstn)
        (flags[i] && !clear_vec[i] && !clear_all)
        |=> flags[i])
        else $error("flag dropped without a clear");
      AST_BIT_NO_SPURIOUS: assert property (@(posedge clk) disable iff (!rstn)
        (!flags[i] && !set_vec[i])
        |=> !flags[i])
        else $error("flag set without a fault");
    end
  endgenerate
  assign fault_latch_status = flags;
  // ==========================================================================
  // Read port
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  always_comb
  begin
    rdata_next = rdata_reg;
    rvalid_next = reg_read;
    if (reg_read)
    begin
      // Unmapped addresses read as zero.
      rdata_next = hit ? flags : `FAULT_STATUS_RESET;
    end
  end
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rdata_reg <= `FAULT_STATUS_RESET;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end
  assign reg_rdata = rdata_reg;
  assign reg_rvalid = rvalid_reg;
  // ==========================================================================
  // Checks: event capture, holding and per-channel power-good clear
  // Each input must land on its own bit, so a swapped channel order is caught here.
  AST_SET_INIT: assert property (@(posedge clk) disable iff (!rstn)
    init_fail_event
    |=> flags[`INIT_FAIL_BIT])
    else $error("init flag not set");
  AST_SET_TSD: assert property (@(posedge clk) disable iff (!rstn)
    thermal_shutdown_event
    |=> flags[`THERMAL_SHUTDOWN_BIT])
    else $error("thermal flag not set");
  genvar c;
  generate
    for (c = 0; c < CHANNELS; c++)
    begin : g_chan_check
      AST_SET_OC: assert property (@(posedge clk) disable iff (!rstn)
        overcurrent_event[c]
        |=> flags[`OVERCURRENT_BASE_BIT + c])
        else $error("overcurrent flag not set");
      AST_SET_PG: assert property (@(posedge clk) disable iff (!rstn)
        power_good_fail_event[c]
        |=> flags[`POWER_GOOD_BASE_BIT + c])
        else $error("power-good flag not set");
      AST_CHAN_W1C_PG: assert property (@(posedge clk) disable iff (!rstn)
        (reg_write && hit && reg_wdata[`POWER_GOOD_BASE_BIT + c] && !power_good_fail_event[c])
        |=> !flags[`POWER_GOOD_BASE_BIT + c])
        else $error("power-good flag not cleared");
    end
  endgenerate
  sequence tsd_pulse_s;
    thermal_shutdown_event ##1 !thermal_shutdown_event;
  endsequence
  sequence no_clear_s;
    !(reg_write && hit && reg_wdata[`THERMAL_SHUTDOWN_BIT]) && !clear_all;
  endsequence
  AST_STICKY: assert property (@(posedge clk) disable iff (!rstn)
    flags[`THERMAL_SHUTDOWN_BIT] ##0 no_clear_s
    |=> flags[`THERMAL_SHUTDOWN_BIT])
    else $error("flag dropped by itself");
  AST_TSD_AFTER_EVENT: assert property (@(posedge clk) disable iff (!rstn)
    tsd_pulse_s ##0 no_clear_s
    |=> flags[`THERMAL_SHUTDOWN_BIT])
    else $error("thermal flag lost when the fault went away");
  // ==========================================================================
  // Checks: clearing
  // A fault that meets a clear is kept, so the host may see it once more but never loses it.
  AST_W1C: assert property (@(posedge clk) disable iff (!rstn)
    (reg_write && hit && reg_wdata[`THERMAL_SHUTDOWN_BIT] && !set_vec[`THERMAL_SHUTDOWN_BIT])
    |=> !flags[`THERMAL_SHUTDOWN_BIT])
    else $error("write one did not clear");
  AST_UNMAPPED_WRITE: assert property (@(posedge clk) disable iff (!rstn)
    (reg_write && !hit && !clear_all && set_vec == `FAULT_STATUS_RESET)
    |=> flags == $past(flags))
    else $error("write to another address changed flags");
  AST_BULK: assert property (@(posedge clk) disable iff (!rstn)
    (clear_all && set_vec == `FAULT_STATUS_RESET)
    |=> flags == `FAULT_STATUS_RESET)
    else $error("bulk clear failed");
  AST_PARTIAL_ENABLES: assert property (@(posedge clk) disable iff (!rstn)
    (channel_enable_inputs != `ENABLES_ALL_LOW && flags[`INIT_FAIL_BIT]
      && !(reg_write && hit && reg_wdata[`INIT_FAIL_BIT]))
    |=> flags[`INIT_FAIL_BIT])
    else $error("flag cleared while a channel stayed enabled");
  AST_SET_BEATS_BULK: assert property (@(posedge clk) disable iff (!rstn)
    (clear_all && init_fail_event)
    |=> flags[`INIT_FAIL_BIT])
    else $error("event lost against all enables low");
  AST_SET_BEATS_W1C: assert property (@(posedge clk) disable iff (!rstn)
    (reg_write && hit && reg_wdata[`OVERCURRENT_BASE_BIT] && set_vec[`OVERCURRENT_BASE_BIT])
    |=> flags[`OVERCURRENT_BASE_BIT])
    else $error("event lost against a write one");
  AST_ZERO_WRITE: assert property (@(posedge clk) disable iff (!rstn)
    (reg_write && hit && !reg_wdata[`INIT_FAIL_BIT] && !clear_all && flags[`INIT_FAIL_BIT])
    |=> flags[`INIT_FAIL_BIT])
    else $error("zero write cleared flag");
  // ==========================================================================
  // Checks: read port and reset
  // Read data is captured on the request edge, so a write in the same cycle is not yet visible.
  sequence read_hit_s;
    reg_read && hit;
  endsequence
  AST_READ: assert property (@(posedge clk) disable iff (!rstn)
    read_hit_s
    |=> (reg_rvalid && reg_rdata == $past(flags)))
    else $error("read data wrong");
  AST_RVALID_ANY: assert property (@(posedge clk) disable iff (!rstn)
    reg_read
    |=> reg_rvalid)
    else $error("read not answered");
  AST_RVALID_PULSE: assert property (@(posedge clk) disable iff (!rstn)
    !reg_read
    |=> !reg_rvalid)
    else $error("read valid without a read");
  AST_RDATA_HOLD: assert property (@(posedge clk) disable iff (!rstn)
    !reg_read
    |=> $stable(reg_rdata))
    else $error("read data changed without a read");
  AST_UNMAPPED_READ: assert property (@(posedge clk) disable iff (!rstn)
    (reg_read && !hit)
    |=> reg_rdata == `FAULT_STATUS_RESET)
    else $error("read of another address not zero");
  AST_RESET_CLEAN: assert property (@(posedge clk) disable iff (!rstn)
    $rose(rstn)
    |-> (flags == `FAULT_STATUS_RESET && !reg_rvalid))
    else $error("state not clear after reset");
endmodule : latched_fault_status
`default_nettype wire

//--- tb/host_model.sv
/*
  Host model: single-byte register reads and writes on the strobe bus.
  Assumes clk is the block clock and the caller waits between transfers.
*/
`timescale 1ns/100ps
`default_nettype none
module host_model
(
  input wire logic clk,
  output logic [7:0] addr,
  output logic wr,
  output logic rd,
  output logic [7:0] wdata
);
  initial {addr, wr, rd, wdata} = 18'h0;
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= ~w;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    // Idle bus shows inverted values so a stale address is never mistaken for a request.
    addr <= ~a;
    wdata <= ~d;
  endtask : xfer
endmodule : host_model
`default_nettype wire

//--- tb/tb_top.sv
/*
  Self-checking bench for the latched fault status register.
  Assumes host_model drives the register strobes.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic clk = 0;
  logic rstn = 0;
  logic [7:0] ev = 8'h00;
  logic [2:0] en = 3'h7;
  logic [7:0] addr, wdata, rdata, st;
  logic wr, rd, rvalid;
  int n_fail = 0;
  int n_checks = 0;
  int cyc = 0;
  initial forever #50 clk = ~clk;
  host_model host (.clk(clk), .addr(addr), .wr(wr), .rd(rd), .wdata(wdata));
  latched_fault_status dut (.clk(clk), .rstn(rstn), .init_fail_event(ev[7]), .overcurrent_event(ev[6:4]),
    .thermal_shutdown_event(ev[3]), .power_good_fail_event(ev[2:0]), .channel_enable_inputs(en),
    .reg_addr(addr), .reg_write(wr), .reg_read(rd), .reg_wdata(wdata), .reg_rdata(rdata),
    .reg_rvalid(rvalid), .fault_latch_status(st));
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task pulse(input logic [7:0] b);
    @(posedge clk);
    ev <= b;
    @(posedge clk);
    ev <= 8'h00;
    #1;
  endtask : pulse
  task wr_chk(input logic [7:0] a, input logic [7:0] d, input logic [7:0] exp);
    host.xfer(1'b1, a, d);
    #1;
    chk(st, exp);
  endtask : wr_chk
  task rd_chk(input logic [7:0] a, input logic [7:0] exp);
    host.xfer(1'b0, a, 8'h00);
    #1;
    chk({7'h0, rvalid}, 8'h01);
    chk(rdata, exp);
    @(posedge clk);
    #1;
    chk({7'h0, rvalid}, 8'h00);
    chk(rdata, exp);
  endtask : rd_chk
  task t_set;
    for (int i = 0; i < 8; i++)
    begin
      pulse(8'h01 << i);
      chk(st, 8'hff >> (7 - i));
    end
    repeat (5) @(posedge clk);
    rd_chk(8'he2, 8'hff);
    $display("t_set done");
  endtask : t_set
  task t_w1c;
    wr_chk(8'he2, 8'h0f, 8'hf0);
    wr_chk(8'he2, 8'h00, 8'hf0);
    wr_chk(8'he1, 8'hff, 8'hf0);
    rd_chk(8'he1, 8'h00);
    fork
      pulse(8'h10);
      host.xfer(1'b1, 8'he2, 8'h10);
    join
    chk(st, 8'hf0);
    $display("t_w1c done");
  endtask : t_w1c
  task t_clear;
    @(posedge clk);
    en <= 3'h3;
    @(posedge clk);
    en <= 3'h0;
    #1;
    chk(st, 8'hf0);
    pulse(8'h80);
    chk(st, 8'h80);
    @(posedge clk);
    en <= 3'h7;
    #1;
    chk(st, 8'h00);
    pulse(8'hff);
    chk(st, 8'hff);
    @(posedge clk);
    rstn <= 1'b0;
    #1;
    chk(st, 8'h00);
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk(st, 8'h00);
    rd_chk(8'he2, 8'h00);
    pulse(8'h08);
    chk(st, 8'h08);
    $display("t_clear done");
  endtask : t_clear
  task final_report;
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : final_report
  // The ceiling leaves ample margin over the roughly 72 cycles the tests need.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_fail++;
      final_report;
    end
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk(st, 8'h00);
    t_set;
    t_w1c;
    t_clear;
    final_report;
  end
endmodule : tb_top
`default_nettype wire
